// ---- core/clcr_rate_decode.v ----
// clcr_rate_decode.v: maps a five-bit rate code to a rate in tenths of Hz/s.
// assumes a combinational use; code 1fh means unlimited and returns zero.
`timescale 1ns/10ps
`include "clcr_map.vh"
module clcr_rate_decode (
  input wire [`CLCR_RATE_W-1:0] code_i,
  output reg [`CLCR_HZ_W+3:0] rate_o,
  output reg unlimited_o
);
  // table in tenths so that 0.5 Hz/s stays an integer
  always @* begin
    unlimited_o = 1'b0;
    case (code_i)
      5'h00: rate_o = 21'h000005;
      5'h01: rate_o = 21'h00000a;
      5'h02: rate_o = 21'h000019;
      5'h03: rate_o = 21'h000032;
      5'h04: rate_o = 21'h00004b;
      5'h05: rate_o = 21'h000064;
      5'h06: rate_o = 21'h0000c8;
      5'h07: rate_o = 21'h000190;
      5'h08: rate_o = 21'h000258;
      5'h09: rate_o = 21'h000320;
      5'h0a: rate_o = 21'h0003e8;
      5'h0b: rate_o = 21'h0007d0;
      5'h0c: rate_o = 21'h000bb8;
      5'h0d: rate_o = 21'h000fa0;
      5'h0e: rate_o = 21'h001388;
      5'h0f: rate_o = 21'h001770;
      5'h10: rate_o = 21'h001b58;
      5'h11: rate_o = 21'h001f40;
      5'h12: rate_o = 21'h002328;
      5'h13: rate_o = 21'h002710;
      5'h14: rate_o = 21'h004e20;
      5'h15: rate_o = 21'h009c40;
      5'h16: rate_o = 21'h00ea60;
      5'h17: rate_o = 21'h013880;
      5'h18: rate_o = 21'h0186a0;
      5'h19: rate_o = 21'h030d40;
      5'h1a: rate_o = 21'h0493e0;
      5'h1b: rate_o = 21'h061a80;
      5'h1c: rate_o = 21'h07a120;
      5'h1d: rate_o = 21'h0927c0;
      5'h1e: rate_o = 21'h0aae60;
      default: begin
        rate_o = 21'h000000;
        unlimited_o = 1'b1;
      end
    endcase
  end
endmodule // clcr_rate_decode

// ---- core/clcr_top.v ----
// clcr_top.v: closed-loop settings register with decoded control outputs.
// assumes a single-cycle host port: write strobe or read strobe, never both.
`timescale 1ns/10ps
`include "clcr_map.vh"
module clcr_top (
  input wire ref_clk_i,
  input wire reset_i,
  input wire [`CLCR_ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  output reg overmod_en_o,
  output reg [`CLCR_RATE_W-1:0] closed_loop_accel_rate_o,
  output reg [`CLCR_RATE_W-1:0] closed_loop_decel_rate_o,
  output reg decel_source_select_o,
  output reg anti_surge_protection_on_o,
  output reg [`CLCR_RATE_W-1:0] eff_decel_code_o,
  output reg decel_field_used_o,
  output reg [`CLCR_HZ_W+3:0] accel_rate_o,
  output reg accel_unlimited_o,
  output reg [`CLCR_HZ_W+3:0] decel_rate_o,
  output reg decel_unlimited_o,
  output reg [3:0] pwm_freq_code_o,
  output reg pwm_mode_o,
  output reg [1:0] fg_sel_o,
  output reg [3:0] fg_div_o,
  output reg fg_config_o,
  output reg [2:0] fg_bemf_thr_o,
  output reg deadtime_comp_en_o,
  output reg speed_loop_dis_o
);
  reg [31:0] closed_loop_settings_reg;
  reg [31:0] closed_loop_settings_next;
  wire hit;
  wire [`CLCR_RATE_W-1:0] acc_code;
  wire [`CLCR_RATE_W-1:0] dec_field;
  wire dsel;
  wire anti_surge_protection;
  wire decel_field_used;
  wire [`CLCR_RATE_W-1:0] eff_dec;
  wire [`CLCR_HZ_W+3:0] acc_hz;
  wire [`CLCR_HZ_W+3:0] dec_hz;
  wire acc_unl;
  wire dec_unl;
  // pass-through fields, named once so each output flop reads a plain wire
  wire overmod_field;
  wire [3:0] pwm_freq_field;
  wire pwm_mode_field;
  wire [1:0] fg_sel_field;
  wire [3:0] fg_div_field;
  wire fg_config_field;
  wire [2:0] fg_bemf_field;
  wire deadtime_field;
  wire speed_dis_field;

  assign hit = (addr_i == `CLCR_SETTINGS_OFS);

  // writes only land in writable bits; reserved bits stay zero
  always @* begin
    closed_loop_settings_next = closed_loop_settings_reg;
    if (wr_i && hit) begin
      closed_loop_settings_next = wdata_i & `CLCR_WR_MASK;
    end
  end

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      closed_loop_settings_reg <= `CLCR_SETTINGS_RST;
    end else begin
      closed_loop_settings_reg <= closed_loop_settings_next;
    end
  end

  // field extraction
  assign acc_code = closed_loop_settings_reg[`CLCR_ACCEL_MSB:`CLCR_ACCEL_LSB];
  assign dec_field = closed_loop_settings_reg[`CLCR_DECEL_MSB:`CLCR_DECEL_LSB];
  assign dsel = closed_loop_settings_reg[`CLCR_DSEL_BIT];
  assign anti_surge_protection = closed_loop_settings_reg[`CLCR_AVS_BIT];

  // fields that only pass through to the motor side; encodings live there
  assign overmod_field = closed_loop_settings_reg[`CLCR_OVERMOD_BIT];
  assign pwm_freq_field = closed_loop_settings_reg[`CLCR_PWMF_MSB:`CLCR_PWMF_LSB];
  assign pwm_mode_field = closed_loop_settings_reg[`CLCR_PWMM_BIT];
  assign fg_sel_field = closed_loop_settings_reg[`CLCR_FGSEL_MSB:`CLCR_FGSEL_LSB];
  assign fg_div_field = closed_loop_settings_reg[`CLCR_FGDIV_MSB:`CLCR_FGDIV_LSB];
  assign fg_config_field = closed_loop_settings_reg[`CLCR_FGCFG_BIT];
  assign fg_bemf_field = closed_loop_settings_reg[`CLCR_BEMF_MSB:`CLCR_BEMF_LSB];
  assign deadtime_field = closed_loop_settings_reg[`CLCR_DTC_BIT];
  assign speed_dis_field = closed_loop_settings_reg[`CLCR_SLD_BIT];

  // with surge protection on, the separate field is not honoured; we then
  // fall back to the acceleration code rather than leave decel undefined
  assign decel_field_used = ~dsel & ~anti_surge_protection;
  assign eff_dec = decel_field_used ? dec_field : acc_code;

  clcr_rate_decode u_acc_dec (
    .code_i(acc_code),
    .rate_o(acc_hz),
    .unlimited_o(acc_unl)
  );

  clcr_rate_decode u_dec_dec (
    .code_i(eff_dec),
    .rate_o(dec_hz),
    .unlimited_o(dec_unl)
  );

  // outputs registered, so decoded values lag the register by one cycle;
  // each output keeps its own flop so the motor side sees no glitches
  // while the host rewrites neighbouring fields

  // read data stands one cycle only; unmapped reads return zero
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i && hit) begin
      rdata_o <= closed_loop_settings_reg & `CLCR_WR_MASK;
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

  // overmodulation permission follows its control bit
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      overmod_en_o <= 1'b0;
    end else begin
      overmod_en_o <= overmod_field;
    end
  end

  // raw acceleration code for the speed ramp
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      closed_loop_accel_rate_o <= 5'h00;
    end else begin
      closed_loop_accel_rate_o <= acc_code;
    end
  end

  // raw deceleration field, shown even while it is not honoured
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      closed_loop_decel_rate_o <= 5'h00;
    end else begin
      closed_loop_decel_rate_o <= dec_field;
    end
  end

  // deceleration source selector
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      decel_source_select_o <= 1'b0;
    end else begin
      decel_source_select_o <= dsel;
    end
  end

  // surge protection enable, also gates the deceleration field
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      anti_surge_protection_on_o <= 1'b0;
    end else begin
      anti_surge_protection_on_o <= anti_surge_protection;
    end
  end

  // deceleration code actually in force; the ramp must read this one,
  // never the raw field, or it would ignore the selector
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      eff_decel_code_o <= 5'h00;
    end else begin
      eff_decel_code_o <= eff_dec;
    end
  end

  // flags when the separate deceleration field is honoured
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      decel_field_used_o <= 1'b0;
    end else begin
      decel_field_used_o <= decel_field_used;
    end
  end

  // decoded acceleration rate in tenths of Hz/s
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      accel_rate_o <= 21'h000000;
    end else begin
      accel_rate_o <= acc_hz;
    end
  end

  // no-limit acceleration; the rate output reads zero then, so the ramp
  // must test this flag first
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      accel_unlimited_o <= 1'b0;
    end else begin
      accel_unlimited_o <= acc_unl;
    end
  end

  // decoded rate of the deceleration code in force
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      decel_rate_o <= 21'h000000;
    end else begin
      decel_rate_o <= dec_hz;
    end
  end

  // no-limit deceleration
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      decel_unlimited_o <= 1'b0;
    end else begin
      decel_unlimited_o <= dec_unl;
    end
  end

  // switching frequency code, passed through undecoded
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      pwm_freq_code_o <= 4'h0;
    end else begin
      pwm_freq_code_o <= pwm_freq_field;
    end
  end

  // modulation scheme select
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      pwm_mode_o <= 1'b0;
    end else begin
      pwm_mode_o <= pwm_mode_field;
    end
  end

  // speed feedback output select
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      fg_sel_o <= 2'h0;
    end else begin
      fg_sel_o <= fg_sel_field;
    end
  end

  // speed feedback divider
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      fg_div_o <= 4'h0;
    end else begin
      fg_div_o <= fg_div_field;
    end
  end

  // speed feedback activity mode
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      fg_config_o <= 1'b0;
    end else begin
      fg_config_o <= fg_config_field;
    end
  end

  // back-emf threshold code for the feedback output
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      fg_bemf_thr_o <= 3'h0;
    end else begin
      fg_bemf_thr_o <= fg_bemf_field;
    end
  end

  // dead-time compensation enable
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      deadtime_comp_en_o <= 1'b0;
    end else begin
      deadtime_comp_en_o <= deadtime_field;
    end
  end

  // speed loop disable
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      speed_loop_dis_o <= 1'b0;
    end else begin
      speed_loop_dis_o <= speed_dis_field;
    end
  end
endmodule // clcr_top

// ---- pkg/clcr_map.vh ----
// clcr_map.vh: offsets, field positions, reset value and rate table size
// for the closed-loop settings register; included by the core files.
`ifndef CLCR_MAP_VH
`define CLCR_MAP_VH
`define CLCR_ADDR_W 8
`define CLCR_SETTINGS_OFS 8'h88
`define CLCR_SETTINGS_RST 32'h00000000
`define CLCR_WR_MASK 32'h7ffffffe
`define CLCR_OVERMOD_BIT 30
`define CLCR_ACCEL_MSB 29
`define CLCR_ACCEL_LSB 25
`define CLCR_DSEL_BIT 24
`define CLCR_DECEL_MSB 23
`define CLCR_DECEL_LSB 19
`define CLCR_PWMF_MSB 18
`define CLCR_PWMF_LSB 15
`define CLCR_PWMM_BIT 14
`define CLCR_FGSEL_MSB 13
`define CLCR_FGSEL_LSB 12
`define CLCR_FGDIV_MSB 11
`define CLCR_FGDIV_LSB 8
`define CLCR_FGCFG_BIT 7
`define CLCR_BEMF_MSB 6
`define CLCR_BEMF_LSB 4
`define CLCR_AVS_BIT 3
`define CLCR_DTC_BIT 2
`define CLCR_SLD_BIT 1
`define CLCR_RATE_W 5
`define CLCR_HZ_W 17
`define CLCR_NO_LIMIT 5'h1f
`endif

// ---- tb/clcr_props.sv ----
// clcr_props.sv: port-level timing checks for the closed-loop settings word.
// assumes one clock and a synchronous active-high reset on clcr_top.
`timescale 1ns/10ps
module clcr_props (
  input wire ref_clk_i,
  input wire reset_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire overmod_en_o,
  input wire [4:0] closed_loop_accel_rate_o,
  input wire [4:0] closed_loop_decel_rate_o,
  input wire decel_source_select_o,
  input wire anti_surge_protection_on_o,
  input wire [4:0] eff_decel_code_o,
  input wire decel_field_used_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // host strobes that hit the settings word
  sequence wr_hit; wr_i && addr_i == 8'h88; endsequence
  sequence rd_hit; rd_i && addr_i == 8'h88; endsequence
  read_back_a: assert property (wr_hit ##1 rd_hit |=>
    rdata_o == ($past(wdata_i, 2) & 32'h7ffffffe)) else $error("readback wrong");
  unmapped_read_a: assert property (rd_i && addr_i != 8'h88 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  overmod_follow_a: assert property (wr_hit |-> ##2 overmod_en_o == $past(wdata_i[30], 2))
    else $error("overmod bit wrong");
  accel_follow_a: assert property (wr_hit |-> ##2
    closed_loop_accel_rate_o == $past(wdata_i[29:25], 2)) else $error("accel code wrong");
  select_follow_a: assert property (wr_hit |-> ##2
    decel_source_select_o == $past(wdata_i[24], 2)) else $error("select bit wrong");
  reset_clear_a: assert property ($fell(reset_i) |-> !decel_source_select_o &&
    !overmod_en_o && rdata_o == 32'h0) else $error("reset value wrong");
  own_decel_a: assert property (decel_field_used_o |->
    eff_decel_code_o == closed_loop_decel_rate_o) else $error("decel field ignored");
  reuse_accel_a: assert property (!decel_field_used_o |->
    eff_decel_code_o == closed_loop_accel_rate_o) else $error("accel code not reused");
  // the used flag resets low and only follows the selector after reset release, so skip the first edges
  field_gate_a: assert property (!$past(reset_i) && !$past(reset_i, 2) && !$past(reset_i, 3) |->
    decel_field_used_o == (!decel_source_select_o && !anti_surge_protection_on_o))
    else $error("decel field gating wrong");
endmodule // clcr_props
bind clcr_top clcr_props u_props (.ref_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .overmod_en_o, .closed_loop_accel_rate_o, .closed_loop_decel_rate_o,
  .decel_source_select_o, .anti_surge_protection_on_o, .eff_decel_code_o, .decel_field_used_o);

// ---- tb/tb.sv ----
// tb.sv: self-checking bench for the closed-loop settings register.
// assumes clcr_top answers reads one cycle later and never stalls the host.
`timescale 1ns/10ps
module tb;
  reg ref_clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg [7:0] addr_i = 8'h00;
  reg [31:0] wdata_i = 32'h0;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  wire [31:0] rdata_o;
  wire [4:0] acc_o, dec_o, eff_o;
  wire [20:0] arate_o, drate_o;
  wire om_o, sel_o, avs_o, used_o;
  wire aunl_o, dunl_o;
  wire [16:0] low_o;
  integer failures = 0;
  integer tests_run = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  clcr_top dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .overmod_en_o(om_o),
    .closed_loop_accel_rate_o(acc_o), .closed_loop_decel_rate_o(dec_o),
    .decel_source_select_o(sel_o), .anti_surge_protection_on_o(avs_o), .eff_decel_code_o(eff_o),
    .decel_field_used_o(used_o), .accel_rate_o(arate_o), .accel_unlimited_o(aunl_o),
    .decel_rate_o(drate_o), .decel_unlimited_o(dunl_o), .pwm_freq_code_o(low_o[16:13]),
    .pwm_mode_o(low_o[12]), .fg_sel_o(low_o[11:10]), .fg_div_o(low_o[9:6]),
    .fg_config_o(low_o[5]), .fg_bemf_thr_o(low_o[4:2]), .deadtime_comp_en_o(low_o[1]),
    .speed_loop_dis_o(low_o[0]));
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // one-cycle strobes; tasks start and end in the time step of a rising edge
  task wr(input [7:0] a, input [31:0] d);
    begin
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
    end
  endtask
  // read data is judged mid-cycle, where it stands clear of both edges
  task rd(input [7:0] a, input [31:0] e);
    begin
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      chk("rdata", e, rdata_o);
      @(posedge ref_clk_i);
    end
  endtask
  // fields land two edges after the write; two more edges keep reads off the launch
  task settle;
    begin
      repeat (3) @(posedge ref_clk_i);
    end
  endtask
  task t_reset;
    begin
      rd(8'h88, 32'h0);
      chk("select", 0, sel_o);
      chk("used", 1, used_o);
      $display("reset test done");
    end
  endtask
  task t_regs;
    begin
      wr(8'h88, 32'hffffffff);
      rd(8'h88, 32'h7ffffffe);
      rd(8'h8c, 32'h0);
      chk("overmod", 1, om_o);
      wr(8'h84, 32'h0);
      rd(8'h88, 32'h7ffffffe);
      wr(8'h88, 32'h80000001);
      rd(8'h88, 32'h0);
      settle;
      chk("overmod", 0, om_o);
      chk("select", 0, sel_o);
      $display("register test done");
    end
  endtask
  // rate codes paired with rates in tenths of Hz/s
  task t_rates;
    reg [24:0] cs;
    reg [59:0] rs;
    reg [4:0] c, d;
    integer i;
    begin
      cs = {5'h0c, 5'h0b, 5'h02, 5'h01, 5'h00};
      rs = {12'hbb8, 12'h7d0, 12'h019, 12'h00a, 12'h005};
      for (i = 0; i < 5; i = i + 1) begin
        c = cs[i*5 +: 5];
        d = cs[(4-i)*5 +: 5];
        wr(8'h88, {2'b00, c, 1'b0, d, 19'h0});
        settle;
        chk("accel", rs[i*12 +: 12], arate_o);
        chk("decel", rs[(4-i)*12 +: 12], drate_o);
        wr(8'h88, {2'b00, c, 1'b0, d, 19'h8});
        settle;
        chk("eff avs", c, eff_o);
        wr(8'h88, {2'b00, c, 1'b1, d, 19'h0});
        settle;
        chk("eff sel", c, eff_o);
        chk("decel sel", rs[i*12 +: 12], drate_o);
      end
      $display("rate test done");
    end
  endtask
  // every pass-through field in both polarities, no-limit codes, mid-run reset
  task t_fields;
    begin
      wr(8'h88, 32'h7efd65e6);
      settle;
      chk("lower fields", {4'ha, 1'h1, 2'h2, 4'h5, 1'h1, 3'h6, 1'h1, 1'h1}, low_o);
      chk("overmod", 1, om_o);
      chk("avs", 0, avs_o);
      chk("decel raw", 5'h1f, dec_o);
      chk("accel nolimit", 1, aunl_o);
      chk("decel nolimit", 1, dunl_o);
      chk("accel", 0, arate_o);
      chk("decel", 0, drate_o);
      wr(8'h88, 32'h01029a18);
      settle;
      chk("lower fields", {4'h5, 1'h0, 2'h1, 4'ha, 1'h0, 3'h1, 1'h0, 1'h0}, low_o);
      chk("overmod", 0, om_o);
      chk("avs", 1, avs_o);
      chk("select", 1, sel_o);
      chk("decel raw", 0, dec_o);
      chk("accel nolimit", 0, aunl_o);
      chk("decel nolimit", 0, dunl_o);
      chk("decel", 12'h005, drate_o);
      reset_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      rd(8'h88, 32'h0);
      chk("lower fields", 0, low_o);
      chk("select", 0, sel_o);
      chk("used", 1, used_o);
      $display("field test done");
    end
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    t_reset;
    t_regs;
    t_rates;
    t_fields;
    give_verdict;
  end
  // guard against a hung run
  initial begin
    #200000;
    failures = failures + 1;
    give_verdict;
  end
endmodule // tb
